// [hdl/bpc_pkg.sv]
package bpc_pkg;
	// register offsets: printed offsets are not all multiples of four, so they are
	// word indices and the byte address is four times the index
	localparam logic [7:0] BPC_IDX_BIAS_B = 8'h47;
	localparam logic [7:0] BPC_IDX_PU_AUDIO = 8'h48;
	localparam logic [7:0] BPC_IDX_PU_CTRL = 8'h49;
	localparam logic [7:0] BPC_IDX_PD_AUDIO = 8'h4a;
	// reset values
	localparam logic [7:0] BPC_RST_BIAS_B = 8'h00;
	localparam logic [7:0] BPC_RST_PU_AUDIO = 8'h7f;
	localparam logic [7:0] BPC_RST_PU_CTRL = 8'h1f;
	localparam logic [7:0] BPC_RST_PD_AUDIO = 8'h00;
	// field positions in the bias register
	localparam int BPC_POS_CBIAS_PD = 6;
	localparam int BPC_POS_FE_HI = 4;
	localparam int BPC_POS_MIC = 2;
	localparam int BPC_POS_DAC = 0;
	// field positions shared by the audio pull-up and pull-down registers
	localparam int BPC_POS_MIC_B = 6;
	localparam int BPC_POS_MIC_A = 5;
	localparam int BPC_POS_FRAME = 4;
	localparam int BPC_POS_BITCLK = 3;
	localparam int BPC_POS_REC_B = 2;
	localparam int BPC_POS_REC_A = 1;
	localparam int BPC_POS_PLAY = 0;
	// field positions in the control pin pull-up register
	localparam int BPC_POS_BOOT = 4;
	localparam int BPC_POS_CCLK = 3;
	localparam int BPC_POS_CDAT = 2;
	localparam int BPC_POS_ADDR_B = 1;
	localparam int BPC_POS_ADDR_A = 0;
	// decoded bias level, one hot, ordered from lowest to highest current
	typedef enum logic [4:0] {
		BPC_LVL_XSAVE = 5'b00001,
		BPC_LVL_SAVE = 5'b00010,
		BPC_LVL_NORMAL = 5'b00100,
		BPC_LVL_ENH = 5'b01000,
		BPC_LVL_SUPER = 5'b10000
	} bpc_level_e;
endpackage

// [hdl/bpc_bias_decode.sv]
`timescale 1ns/1ps
// decodes one two-bit bias selector into a one-hot level
module bpc_bias_decode
	import bpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] sel,
	input wire logic dac_map,
	output logic [4:0] level
);
	// two codings: the converter table differs in codes 01..11
	function automatic logic [4:0] decode(input logic [1:0] s, input logic d);
		logic [4:0] v;
		v = BPC_LVL_NORMAL;
		unique case (s)
			2'b00: v = BPC_LVL_NORMAL;
			2'b01: v = d ? BPC_LVL_SAVE : BPC_LVL_XSAVE;
			2'b10: v = d ? BPC_LVL_SUPER : BPC_LVL_ENH;
			2'b11: v = d ? BPC_LVL_ENH : BPC_LVL_SAVE;
		endcase
		return v;
	endfunction

	wire [4:0] level_nxt = decode(sel, dac_map);

	// registered so the analog control is glitch free
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= BPC_LVL_NORMAL;
		end else begin
			level <= level_nxt;
		end
	end
endmodule

// [hdl/bpc_apb_slave.sv]
`timescale 1ns/1ps
// apb slave front end: no ready logic of its own, flags every access-phase cycle
module bpc_apb_slave
	import bpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	output logic [7:0] idx,
	output logic aligned,
	output logic wr_stb,
	output logic rd_stb
);
	// index is the word address; byte offset must be zero
	assign idx = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	// strobe held in every access-phase cycle of a transfer, the wait state too
	assign wr_stb = psel && penable && pwrite;
	assign rd_stb = psel && penable && !pwrite;
endmodule

// [hdl/bpc_regs.sv]
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// Operation
// - bit 6 set powers central bias down
// - front-end pair field bits 5:4 decode
// - microphone bias field bits 3:2 decode
// - converter bias field bits 1:0, own mapping
// - audio pull-up register, reset 7f, 1=off
// - audio pull-up bit to pin mapping
// - control pull-up register, reset 1f, 1=off
// - audio pull-down register, reset 00, 1=on
// - pull-down bits follow pull-up pin order
// - bias register at 47, reset zero
module bpc_regs
	import bpc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic central_bias_powerdown,
	output logic [1:0] frontend_hi_pair_bias_sel,
	output logic [1:0] mic_input_bias_sel,
	output logic [1:0] output_converter_bias_sel,
	output logic [4:0] frontend_hi_pair_bias_level,
	output logic [4:0] mic_input_bias_level,
	output logic [4:0] output_converter_bias_level,
	output logic mic_pair_b_pullup_off,
	output logic mic_pair_a_pullup_off,
	output logic frame_clock_pullup_off,
	output logic bit_clock_pullup_off,
	output logic record_out_b_pullup_off,
	output logic record_out_a_pullup_off,
	output logic playback_in_pullup_off,
	output logic boot_pin_pullup_off,
	output logic ctrl_clock_pullup_off,
	output logic ctrl_data_pullup_off,
	output logic addr_pin_b_pullup_off,
	output logic addr_pin_a_pullup_off,
	output logic mic_pair_b_pulldown_on,
	output logic mic_pair_a_pulldown_on,
	output logic frame_clock_pulldown_on,
	output logic bit_clock_pulldown_on,
	output logic record_out_b_pulldown_on,
	output logic record_out_a_pulldown_on,
	output logic playback_in_pulldown_on
);
	logic [7:0] idx; // word index of the access
	logic aligned; // access lands on a word boundary inside the map
	logic wr_stb; // write access cycle
	logic rd_stb; // read access cycle

	bpc_apb_slave u_apb (
		.clk(sys_clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.idx(idx),
		.aligned(aligned),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb)
	);

	// the four storage registers
	logic [7:0] bias_b_r;
	logic [7:0] pu_audio_r;
	logic [7:0] pu_ctrl_r;
	logic [7:0] pd_audio_r;

	// address decode
	wire hit_bias = aligned && (idx == BPC_IDX_BIAS_B);
	wire hit_pua = aligned && (idx == BPC_IDX_PU_AUDIO);
	wire hit_puc = aligned && (idx == BPC_IDX_PU_CTRL);
	wire hit_pda = aligned && (idx == BPC_IDX_PD_AUDIO);
	wire hit_any = hit_bias || hit_pua || hit_puc || hit_pda;
	// only byte lane 0 carries data; a write without it changes nothing
	wire lane0 = pstrb[0];
	wire [7:0] wbyte = pwdata[7:0];

	// write enables; reserved bits are kept so reads give back what was written
	// the byte lands only at the completing edge, when ready is high, so a
	// master that sees the wait state never finds the register changed early
	wire we_bias = wr_stb && pready && hit_bias && lane0;
	wire we_pua = wr_stb && pready && hit_pua && lane0;
	wire we_puc = wr_stb && pready && hit_puc && lane0;
	wire we_pda = wr_stb && pready && hit_pda && lane0;

	// read mux, upper bits read zero
	wire [7:0] rbyte = hit_bias ? bias_b_r :
		hit_pua ? pu_audio_r :
		hit_puc ? pu_ctrl_r :
		hit_pda ? pd_audio_r : 8'h00;
	wire [31:0] prdata_nxt = rd_stb ? {24'h000000, rbyte} : prdata;
	// unmapped or misaligned access is answered with an error, no side effect
	wire pslverr_nxt = psel && !penable && !(aligned && hit_any);

	// storage registers; asynchronous reset loads documented values
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bias_b_r <= BPC_RST_BIAS_B;
			pu_audio_r <= BPC_RST_PU_AUDIO;
			pu_ctrl_r <= BPC_RST_PU_CTRL;
			pd_audio_r <= BPC_RST_PD_AUDIO;
		end else begin
			if (we_bias) begin
				bias_b_r <= wbyte;
			end
			if (we_pua) begin
				pu_audio_r <= wbyte;
			end
			if (we_puc) begin
				pu_ctrl_r <= wbyte;
			end
			if (we_pda) begin
				pd_audio_r <= wbyte;
			end
		end
	end

	// bus answer: read data is registered, so the slave inserts one wait state
	// for reads and writes alike; ready pulses in the second access cycle
	logic ready_r;
	wire ready_nxt = psel && penable && !ready_r;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ready_r <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			ready_r <= ready_nxt;
			if (psel && penable && !ready_r) begin
				prdata <= prdata_nxt;
			end
			if (psel && !penable) begin
				pslverr <= pslverr_nxt;
			end
		end
	end
	assign pready = ready_r;

	// decoded bias levels
	bpc_bias_decode u_dec_fe (
		.clk(sys_clk),
		.rst(rst),
		.sel(bias_b_r[BPC_POS_FE_HI +: 2]),
		.dac_map(1'b0),
		.level(frontend_hi_pair_bias_level)
	);
	bpc_bias_decode u_dec_mic (
		.clk(sys_clk),
		.rst(rst),
		.sel(bias_b_r[BPC_POS_MIC +: 2]),
		.dac_map(1'b0),
		.level(mic_input_bias_level)
	);
	bpc_bias_decode u_dec_dac (
		.clk(sys_clk),
		.rst(rst),
		.sel(bias_b_r[BPC_POS_DAC +: 2]),
		.dac_map(1'b1),
		.level(output_converter_bias_level)
	);

	// raw fields straight from the storage flip-flops
	assign central_bias_powerdown = bias_b_r[BPC_POS_CBIAS_PD];
	assign frontend_hi_pair_bias_sel = bias_b_r[BPC_POS_FE_HI +: 2];
	assign mic_input_bias_sel = bias_b_r[BPC_POS_MIC +: 2];
	assign output_converter_bias_sel = bias_b_r[BPC_POS_DAC +: 2];

	// audio pin pull-ups, set means off
	assign mic_pair_b_pullup_off = pu_audio_r[BPC_POS_MIC_B];
	assign mic_pair_a_pullup_off = pu_audio_r[BPC_POS_MIC_A];
	assign frame_clock_pullup_off = pu_audio_r[BPC_POS_FRAME];
	assign bit_clock_pullup_off = pu_audio_r[BPC_POS_BITCLK];
	assign record_out_b_pullup_off = pu_audio_r[BPC_POS_REC_B];
	assign record_out_a_pullup_off = pu_audio_r[BPC_POS_REC_A];
	assign playback_in_pullup_off = pu_audio_r[BPC_POS_PLAY];

	// control pin pull-ups, set means off
	assign boot_pin_pullup_off = pu_ctrl_r[BPC_POS_BOOT];
	assign ctrl_clock_pullup_off = pu_ctrl_r[BPC_POS_CCLK];
	assign ctrl_data_pullup_off = pu_ctrl_r[BPC_POS_CDAT];
	assign addr_pin_b_pullup_off = pu_ctrl_r[BPC_POS_ADDR_B];
	assign addr_pin_a_pullup_off = pu_ctrl_r[BPC_POS_ADDR_A];

	// audio pin pull-downs, same pin order as the pull-ups
	assign mic_pair_b_pulldown_on = pd_audio_r[BPC_POS_MIC_B];
	assign mic_pair_a_pulldown_on = pd_audio_r[BPC_POS_MIC_A];
	assign frame_clock_pulldown_on = pd_audio_r[BPC_POS_FRAME];
	assign bit_clock_pulldown_on = pd_audio_r[BPC_POS_BITCLK];
	assign record_out_b_pulldown_on = pd_audio_r[BPC_POS_REC_B];
	assign record_out_a_pulldown_on = pd_audio_r[BPC_POS_REC_A];
	assign playback_in_pulldown_on = pd_audio_r[BPC_POS_PLAY];
endmodule

// [dv/bpc_regs_props.sv]
`timescale 1ns/1ps
// bus timing and bias register behaviour seen at the top ports
module bpc_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic central_bias_powerdown,
	input wire logic [1:0] frontend_hi_pair_bias_sel,
	input wire logic [1:0] mic_input_bias_sel,
	input wire logic [1:0] output_converter_bias_sel
);
	// completing access; a bias write only counts when accepted
	wire done = psel && penable && pready;
	wire bwr = done && pwrite && pstrb[0] && !pslverr && paddr == 12'h11c;
	wire [6:0] bias = {central_bias_powerdown, frontend_hi_pair_bias_sel,
		mic_input_bias_sel, output_converter_bias_sel};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_setup_quiet: assert property (psel && !penable |-> !pready)
		else $error("pready in setup");
	a_bias_write: assert property (bwr |=> bias == $past(pwdata[6:0]))
		else $error("bias fields not written");
	a_bias_hold: assert property (!bwr |=> $stable(bias))
		else $error("bias changed without write");
	a_bias_read: assert property (done && !pwrite && paddr == 12'h11c |-> prdata[6:0] == bias)
		else $error("bias read mismatch");
	a_upper_zero: assert property (done && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_bad_align: assert property (done && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access taken");
endmodule
bind bpc_regs bpc_props u_props (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr, .central_bias_powerdown, .frontend_hi_pair_bias_sel,
	.mic_input_bias_sel, .output_converter_bias_sel);

// [dv/bias_and_pad_pull_config_tb.sv]
`timescale 1ns/1ps
module bias_and_pad_pull_config_tb;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [3:0] pstrb = 0;
	wire [31:0] prdata;
	wire pready, pslverr, cb;
	wire [1:0] fs, ms, ds;
	wire [4:0] fl, ml, dl, uc;
	wire [6:0] ua, da;
	logic [31:0] q[$];
	logic [7:0] sh[4];
	logic [11:0] ad[4] = '{12'h11c, 12'h120, 12'h124, 12'h128};
	logic [4:0] ft[4] = '{5'h04, 5'h01, 5'h08, 5'h02}, dt[4] = '{5'h04, 5'h02, 5'h10, 5'h08};
	int fail_count = 0, check_count = 0, seed = 32'hd73e8b06, i, k;
	always #25 sys_clk = ~sys_clk;
	bpc_regs u_bpc_regs (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .central_bias_powerdown(cb),
		.frontend_hi_pair_bias_sel(fs), .mic_input_bias_sel(ms),
		.output_converter_bias_sel(ds), .frontend_hi_pair_bias_level(fl),
		.mic_input_bias_level(ml), .output_converter_bias_level(dl),
		.mic_pair_b_pullup_off(ua[6]), .mic_pair_a_pullup_off(ua[5]),
		.frame_clock_pullup_off(ua[4]), .bit_clock_pullup_off(ua[3]),
		.record_out_b_pullup_off(ua[2]), .record_out_a_pullup_off(ua[1]),
		.playback_in_pullup_off(ua[0]), .boot_pin_pullup_off(uc[4]),
		.ctrl_clock_pullup_off(uc[3]), .ctrl_data_pullup_off(uc[2]),
		.addr_pin_b_pullup_off(uc[1]), .addr_pin_a_pullup_off(uc[0]),
		.mic_pair_b_pulldown_on(da[6]), .mic_pair_a_pulldown_on(da[5]),
		.frame_clock_pulldown_on(da[4]), .bit_clock_pulldown_on(da[3]),
		.record_out_b_pulldown_on(da[2]), .record_out_a_pulldown_on(da[1]),
		.playback_in_pulldown_on(da[0]));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// read data is compared against the oldest noted value
	always @(posedge sys_clk) if (psel && penable && pready && !pwrite)
		chk("prdata", q.pop_front(), prdata);
	// one transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
		int n;
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, 24'h0, d, s};
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 9);
		if (pready !== 1'b1) begin
			fail_count++;
			end_of_test;
		end
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic wr(input int j, input logic [7:0] d);
		apb(1, ad[j], d, 4'h1);
		sh[j] = d;
		chk("pslverr_ok", 32'h0, 32'(err));
	endtask
	task automatic rall;
		for (int j = 0; j < 4; j++) begin
			q.push_back(32'(sh[j]));
			apb(0, ad[j], 8'h0, 4'h1);
		end
	endtask
	// pad outputs against the shadow copy
	task automatic outs;
		chk("bias", 32'(sh[0][6:0]), 32'({cb, fs, ms, ds}));
		chk("pu_audio", 32'(sh[1][6:0]), 32'(ua));
		chk("pu_ctrl", 32'(sh[2][4:0]), 32'(uc));
		chk("pd_audio", 32'(sh[3][6:0]), 32'(da));
	endtask
	initial begin
		sh = '{8'h00, 8'h7f, 8'h1f, 8'h00};
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		outs;
		rall;
		// every selector code on all bias fields, central bias both ways
		for (k = 0; k < 4; k++) begin
			wr(0, {1'b0, k[0], k[1:0], k[1:0], k[1:0]});
			repeat (2) @(posedge sys_clk);
			chk("fe_lvl", 32'(ft[k]), 32'(fl));
			chk("mic_lvl", 32'(ft[k]), 32'(ml));
			chk("dac_lvl", 32'(dt[k]), 32'(dl));
			outs;
		end
		// random contents, reserved bits too
		for (i = 0; i < 12; i++) begin
			wr(i % 4, 8'($random(seed)));
			// the write lands at the completing edge; look one edge later
			@(posedge sys_clk);
			outs;
		end
		rall;
		// refused accesses must leave every register alone
		apb(1, 12'h12c, 8'hff, 4'h1);
		chk("pslverr", 32'h1, 32'(err));
		apb(1, 12'h121, 8'hff, 4'h1);
		chk("pslverr", 32'h1, 32'(err));
		// unmapped read answers with an error and zero data
		q.push_back(32'h0);
		apb(0, 12'h12c, 8'h00, 4'h1);
		chk("pslverr", 32'h1, 32'(err));
		apb(1, ad[2], 8'h00, 4'h0);
		rall;
		// reset in mid run restores everything at once
		@(posedge sys_clk);
		rst <= 1;
		#1;
		sh = '{8'h00, 8'h7f, 8'h1f, 8'h00};
		outs;
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		rall;
		end_of_test;
	end
endmodule
